// *** design/clii_pkg.sv ***
// Constants, codes and types shared by both ends of the character LCD instruction link.
// Assumes one 250 MHz clock on both ends and a write-only parallel bus between them.
// Notes on behaviour
// - Host initialises by commands when power-on reset fails.
// - Two-line mode gives each row 40 bytes.
// - Host rewrites address after eighth visible character.
// - Display shift moves both rows, never across.
// - Function set 001110 selects 8-bit, two-line, small font.
// - Code 00001110 turns display and cursor on.
// - Entry code 00000110 increments address, no shift.
// - Entry code 00000111 also scrolls display per write to character memory.
// - Address code 11000000 points at second row start.
// - Data write stores code; character memory selected first.
// - Cursor home zeroes shift and address and reselects character memory.
// - Power-on reset leaves the display off.
// - In 4-bit mode two accesses form one byte.
// - Device starts in 8-bit bus mode.
// - 4-bit host sends function set once, then split.
// - Device ignores low lines in 4-bit mode.
`default_nettype none
package clii_pkg;
    // Link timing in nanoseconds and the derived clock counts.
    localparam int CLK_PERIOD_NS = 4;
    localparam int SETUP_NS = 40;
    localparam int STROBE_HIGH_NS = 240;
    localparam int HOLD_NS = 40;
    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;

    // Memory geometry.
    localparam int DD_DEPTH = 80;
    localparam int CG_DEPTH = 64;
    localparam logic [6:0] ROW_LEN = 7'h28;
    localparam logic [5:0] ROW_LAST = 6'h27;
    localparam logic [6:0] DD_LAST = 7'h4f;
    localparam logic [7:0] BLANK_CODE = 8'h20;

    // Instruction field positions.
    localparam int FS_DL_BIT = 4;
    localparam int FS_N_BIT = 3;
    localparam int FS_F_BIT = 2;
    localparam int DISP_D_BIT = 2;
    localparam int DISP_C_BIT = 1;
    localparam int DISP_B_BIT = 0;
    localparam int ENTRY_ID_BIT = 1;
    localparam int ENTRY_S_BIT = 0;
    localparam int SHIFT_SC_BIT = 3;
    localparam int SHIFT_RL_BIT = 2;

    // Host register map and fields.
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_MODE = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam int CMD_SEL_BIT = 8;
    localparam int CMD_SINGLE_BIT = 9;
    localparam int MODE_FOUR_BIT = 0;
    localparam int STATUS_BUSY_BIT = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        CLII_IDLE = 2'b00,
        CLII_SETUP = 2'b01,
        CLII_STROBE = 2'b10,
        CLII_HOLD = 2'b11
    } clii_state_t;
endpackage
`default_nettype wire

// *** design/clii_bus_if.sv ***
// Parallel instruction bus between the host controller and the LCD controller.
// Assumes both ends run on the same clock; the device synchronises the pins anyway.
`timescale 1ns/10ps
`default_nettype none
interface clii_bus_if;
    logic strobe;
    logic instr_data_select;
    logic read_not_write;
    logic [3:0] high_nibble_lines;
    logic [3:0] low_nibble_lines;

    modport host (
        output strobe,
        output instr_data_select,
        output read_not_write,
        output high_nibble_lines,
        output low_nibble_lines
    );

    modport dev (
        input strobe,
        input instr_data_select,
        input read_not_write,
        input high_nibble_lines,
        input low_nibble_lines
    );
endinterface
`default_nettype wire

// *** design/clii_device.sv ***
// LCD controller end: decodes instructions and data from the parallel bus.
// Assumes the host holds every pin stable from setup until after the strobe falls.
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module clii_device (
    clii_bus_if.dev bus,
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [6:0] rd_index,
    output logic [7:0] rd_char,
    input wire logic [5:0] glyph_rd_index,
    output logic [7:0] glyph_rd_data,
    output logic display_on,
    output logic cursor_on,
    output logic blink_on,
    output logic two_line,
    output logic font_large,
    output logic bus_8bit,
    output logic glyph_selected,
    output logic [6:0] cursor_addr,
    output logic [6:0] display_shift
);
    import clii_pkg::*;

    logic strobe_s1, strobe_s2, strobe_s3;
    logic sel_s1, sel_s2;
    logic rw_s1, rw_s2;
    logic [3:0] hi_s1, hi_s2;
    logic [3:0] lo_s1, lo_s2;
    logic second_half;
    logic [3:0] held_high;
    logic inc_mode;
    logic shift_on_write;
    logic [5:0] glyph_addr;
    logic [7:0] char_code_ram [DD_DEPTH];
    logic [7:0] glyph_ram [CG_DEPTH];

    logic access;
    logic cmd_valid;
    logic [7:0] cmd_byte;
    logic is_instr, is_data;
    logic is_clear, is_home, is_entry, is_disp, is_shift, is_func, is_cg_addr, is_dd_addr;
    logic dd_write, cg_write;
    logic [6:0] dd_idx;
    logic dd_ok;

    function automatic logic [6:0] step_dd(input logic [6:0] a, input logic up,
                                           input logic two);
        logic [6:0] r;
        r = a;
        if (two) begin
            if (up) begin
                r = (a[5:0] == ROW_LAST) ? {~a[6], 6'h00} : a + 7'h01;
            end else begin
                r = (a[5:0] == 6'h00) ? {~a[6], ROW_LAST} : a - 7'h01;
            end
        end else begin
            if (up) begin
                r = (a == DD_LAST) ? 7'h00 : a + 7'h01;
            end else begin
                r = (a == 7'h00) ? DD_LAST : a - 7'h01;
            end
        end
        return r;
    endfunction

    function automatic logic [6:0] step_shift(input logic [6:0] s, input logic up,
                                              input logic two);
        logic [6:0] last;
        logic [6:0] r;
        last = two ? {1'b0, ROW_LAST} : DD_LAST;
        if (up) begin
            r = (s >= last) ? 7'h00 : s + 7'h01;
        end else begin
            r = (s == 7'h00) ? last : s - 7'h01;
        end
        return r;
    endfunction

    // Pins come from the other party and pass two flip-flops first.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strobe_s1 <= 1'b0;
            strobe_s2 <= 1'b0;
            strobe_s3 <= 1'b0;
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
            rw_s1 <= 1'b0;
            rw_s2 <= 1'b0;
            hi_s1 <= 4'h0;
            hi_s2 <= 4'h0;
            lo_s1 <= 4'h0;
            lo_s2 <= 4'h0;
        end else begin
            strobe_s1 <= bus.strobe;
            strobe_s2 <= strobe_s1;
            strobe_s3 <= strobe_s2;
            sel_s1 <= bus.instr_data_select;
            sel_s2 <= sel_s1;
            rw_s1 <= bus.read_not_write;
            rw_s2 <= rw_s1;
            hi_s1 <= bus.high_nibble_lines;
            hi_s2 <= hi_s1;
            lo_s1 <= bus.low_nibble_lines;
            lo_s2 <= lo_s1;
        end
    end

    // A write access completes on the falling edge of the strobe.
    assign access = strobe_s3 & ~strobe_s2 & ~rw_s2;

    // Byte assembly: one access in 8-bit mode, two in 4-bit mode.
    always_comb begin
        cmd_valid = 1'b0;
        cmd_byte = {hi_s2, lo_s2};
        if (access) begin
            if (bus_8bit) begin
                cmd_valid = 1'b1;
            end else if (second_half) begin
                cmd_valid = 1'b1;
                cmd_byte = {held_high, hi_s2};
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            second_half <= 1'b0;
            held_high <= 4'h0;
        end else if (access && !bus_8bit) begin
            second_half <= ~second_half;
            if (!second_half) begin
                held_high <= hi_s2;
            end
        end else if (bus_8bit) begin
            second_half <= 1'b0;
        end
    end

    assign is_instr = cmd_valid & ~sel_s2;
    assign is_data = cmd_valid & sel_s2;
    assign is_dd_addr = is_instr & cmd_byte[7];
    assign is_cg_addr = is_instr & (cmd_byte[7:6] == 2'b01);
    assign is_func = is_instr & (cmd_byte[7:5] == 3'b001);
    assign is_shift = is_instr & (cmd_byte[7:4] == 4'b0001);
    assign is_disp = is_instr & (cmd_byte[7:3] == 5'b00001);
    assign is_entry = is_instr & (cmd_byte[7:2] == 6'b000001);
    assign is_home = is_instr & (cmd_byte[7:1] == 7'b0000001);
    assign is_clear = is_instr & (cmd_byte == 8'h01);

    // Two-line mode maps each row onto its own 40-byte block.
    assign dd_idx = two_line ? (cursor_addr[6] ? ROW_LEN + {1'b0, cursor_addr[5:0]}
                                                : {1'b0, cursor_addr[5:0]})
                             : cursor_addr;
    assign dd_ok = two_line ? (cursor_addr[5:0] <= ROW_LAST) : (cursor_addr <= DD_LAST);
    assign dd_write = is_data & ~glyph_selected & dd_ok;
    assign cg_write = is_data & glyph_selected;

    // Mode and display control, defaults set by the power-on reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_8bit <= 1'b1;
            two_line <= 1'b0;
            font_large <= 1'b0;
            display_on <= 1'b0;
            cursor_on <= 1'b0;
            blink_on <= 1'b0;
            inc_mode <= 1'b1;
            shift_on_write <= 1'b0;
        end else begin
            if (is_func) begin
                bus_8bit <= cmd_byte[FS_DL_BIT];
                two_line <= cmd_byte[FS_N_BIT];
                font_large <= cmd_byte[FS_F_BIT];
            end
            if (is_disp) begin
                display_on <= cmd_byte[DISP_D_BIT];
                cursor_on <= cmd_byte[DISP_C_BIT];
                blink_on <= cmd_byte[DISP_B_BIT];
            end
            if (is_entry) begin
                inc_mode <= cmd_byte[ENTRY_ID_BIT];
                shift_on_write <= cmd_byte[ENTRY_S_BIT];
            end
            if (is_clear) begin
                inc_mode <= 1'b1;
            end
        end
    end

    // Address pointers and memory selection.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cursor_addr <= 7'h00;
            glyph_addr <= 6'h00;
            glyph_selected <= 1'b0;
        end else if (is_clear || is_home) begin
            cursor_addr <= 7'h00;
            glyph_selected <= 1'b0;
        end else if (is_dd_addr) begin
            cursor_addr <= cmd_byte[6:0];
            glyph_selected <= 1'b0;
        end else if (is_cg_addr) begin
            glyph_addr <= cmd_byte[5:0];
            glyph_selected <= 1'b1;
        end else if (is_shift && !cmd_byte[SHIFT_SC_BIT]) begin
            cursor_addr <= step_dd(cursor_addr, cmd_byte[SHIFT_RL_BIT], two_line);
        end else if (is_shift) begin
            cursor_addr <= step_dd(cursor_addr, cmd_byte[SHIFT_RL_BIT], two_line);
        end else if (cg_write) begin
            glyph_addr <= inc_mode ? glyph_addr + 6'h01 : glyph_addr - 6'h01;
        end else if (is_data) begin
            cursor_addr <= step_dd(cursor_addr, inc_mode, two_line);
        end
    end

    // One shift offset serves both rows and wraps within a row.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            display_shift <= 7'h00;
        end else if (is_clear || is_home) begin
            display_shift <= 7'h00;
        end else if (is_shift && cmd_byte[SHIFT_SC_BIT]) begin
            display_shift <= step_shift(display_shift, cmd_byte[SHIFT_RL_BIT],
                                        two_line);
        end else if (dd_write && shift_on_write) begin
            display_shift <= step_shift(display_shift, inc_mode, two_line);
        end
    end

    // Character storage; only a clear or a data write alters it.
    always_ff @(posedge aclk) begin
        if (is_clear) begin
            for (int i = 0; i < DD_DEPTH; i++) begin
                char_code_ram[i] <= BLANK_CODE;
            end
        end else if (dd_write) begin
            char_code_ram[dd_idx] <= cmd_byte;
        end
    end

    always_ff @(posedge aclk) begin
        if (cg_write) begin
            glyph_ram[glyph_addr] <= cmd_byte;
        end
    end

    // Read ports for the panel drive side.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_char <= 8'h00;
            glyph_rd_data <= 8'h00;
        end else begin
            rd_char <= (rd_index <= DD_LAST) ? char_code_ram[rd_index] : BLANK_CODE;
            glyph_rd_data <= glyph_ram[glyph_rd_index];
        end
    end
endmodule
`default_nettype wire

// *** design/clii_host.sv ***
// Host controller end: takes orders over AXI4-Lite and drives the parallel bus.
// Assumes software issues the start-up sequence itself and watches the busy flag.
`timescale 1ns/10ps
`default_nettype none
module clii_host (
    clii_bus_if.host bus,
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import clii_pkg::*;

    clii_state_t state;
    logic [CNT_W-1:0] count;
    logic four_bit;
    logic [9:0] last_cmd;
    logic second;
    logic take_write, start;
    logic [3:0] waddr;

    assign take_write = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_awready = take_write;
    assign s_axi_wready = take_write;
    assign s_axi_arready = ~s_axi_rvalid;
    assign waddr = s_axi_awaddr[3:0];
    assign start = take_write & (waddr == REG_CMD) & s_axi_wstrb[0] & (state == CLII_IDLE);

    // Write response; a command while busy or an unmapped address is refused.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (take_write) begin
            s_axi_bvalid <= 1'b1;
            if (waddr == REG_MODE || start || (waddr == REG_CMD && !s_axi_wstrb[0])) begin
                s_axi_bresp <= RESP_OKAY;
            end else begin
                s_axi_bresp <= RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            four_bit <= 1'b0;
        end else if (take_write && waddr == REG_MODE && s_axi_wstrb[0]) begin
            four_bit <= s_axi_wdata[MODE_FOUR_BIT];
        end
    end

    // Read channel.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (s_axi_araddr[3:0])
                REG_CMD: s_axi_rdata <= {22'h000000, last_cmd};
                REG_MODE: s_axi_rdata <= {31'h00000000, four_bit};
                REG_STATUS: s_axi_rdata <= {31'h00000000, state != CLII_IDLE};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Access sequencer: setup, strobe high, hold, and a second access for 4-bit mode.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= CLII_IDLE;
            count <= '0;
            second <= 1'b0;
            last_cmd <= 10'h000;
            bus.strobe <= 1'b0;
            bus.instr_data_select <= 1'b0;
            bus.read_not_write <= 1'b0;
            bus.high_nibble_lines <= 4'h0;
            bus.low_nibble_lines <= 4'h0;
        end else begin
            case (state)
                CLII_IDLE: begin
                    if (start) begin
                        last_cmd <= s_axi_wdata[9:0];
                        second <= 1'b0;
                        bus.instr_data_select <= s_axi_wdata[CMD_SEL_BIT];
                        bus.high_nibble_lines <= s_axi_wdata[7:4];
                        bus.low_nibble_lines <= four_bit ? 4'h0 : s_axi_wdata[3:0];
                        count <= CNT_W'(SETUP_CYC - 1);
                        state <= CLII_SETUP;
                    end
                end
                CLII_SETUP: begin
                    if (count == '0) begin
                        bus.strobe <= 1'b1;
                        count <= CNT_W'(STROBE_CYC - 1);
                        state <= CLII_STROBE;
                    end else begin
                        count <= count - 1'b1;
                    end
                end
                CLII_STROBE: begin
                    if (count == '0) begin
                        bus.strobe <= 1'b0;
                        count <= CNT_W'(HOLD_CYC - 1);
                        state <= CLII_HOLD;
                    end else begin
                        count <= count - 1'b1;
                    end
                end
                CLII_HOLD: begin
                    if (count != '0) begin
                        count <= count - 1'b1;
                    end else if (four_bit && !second && !last_cmd[CMD_SINGLE_BIT]) begin
                        second <= 1'b1;
                        bus.high_nibble_lines <= last_cmd[3:0];
                        count <= CNT_W'(SETUP_CYC - 1);
                        state <= CLII_SETUP;
                    end else begin
                        state <= CLII_IDLE;
                    end
                end
                default: state <= CLII_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** test/clii_bus_props.sv ***
// Checker for the parallel link between the host and device ends.
// Assumes it sees the link pins and the shared clock and reset directly.
`timescale 1ns/10ps
`default_nettype none
module clii_bus_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic strobe,
    input wire logic instr_data_select,
    input wire logic read_not_write,
    input wire logic [3:0] high_nibble_lines,
    input wire logic [3:0] low_nibble_lines
);
    import clii_pkg::*;
    logic [8:0] lines;
    logic [8:0] lines_prev;
    logic [CNT_W-1:0] quiet;
    logic [CNT_W-1:0] since_fall;
    logic [CNT_W-1:0] high_run;
    assign lines = {instr_data_select, high_nibble_lines, low_nibble_lines};

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Cycles the lines have stayed unchanged.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lines_prev <= '0;
            quiet <= '1;
        end else begin
            lines_prev <= lines;
            if (lines != lines_prev) quiet <= '0;
            else if (quiet != '1) quiet <= quiet + 1'b1;
        end
    end

    // Cycles since the strobe fell, and length of the present strobe.
    always_ff @(posedge aclk) begin
        if (!aresetn) since_fall <= '1;
        else if (strobe) since_fall <= '0;
        else if (since_fall != '1) since_fall <= since_fall + 1'b1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) high_run <= '0;
        else if (strobe) high_run <= high_run + 1'b1;
        else high_run <= '0;
    end

    a_write_only: assert property (!read_not_write)
        else $error("Link read access seen.");
    a_reset_idle: assert property ($rose(aresetn) |-> !strobe && lines == 9'h000)
        else $error("Link not idle after reset.");
    a_strobe_run: assert property ($rose(strobe) |-> strobe [*8])
        else $error("Strobe pulse too short.");
    a_strobe_len: assert property ($fell(strobe) |-> high_run == STROBE_CYC)
        else $error("Strobe length wrong.");
    a_strobe_max: assert property (high_run <= STROBE_CYC)
        else $error("Strobe held too long.");
    a_lines_stable: assert property (strobe |-> lines == lines_prev)
        else $error("Lines moved under strobe.");
    a_setup_time: assert property ($rose(strobe) |-> quiet >= SETUP_CYC - 1)
        else $error("Setup time too short.");
    a_hold_time: assert property (
        !strobe && lines != lines_prev |-> since_fall >= HOLD_CYC)
        else $error("Hold time too short.");
    a_access_gap: assert property (
        $rose(strobe) |-> since_fall >= SETUP_CYC + HOLD_CYC)
        else $error("Accesses too close.");
endmodule
`default_nettype wire

// *** test/char_lcd_instruction_interface_tb.sv ***
// Testbench joining the host and device ends through the link interface.
// Assumes software orders arrive over AXI4-Lite and device state is read at its outputs.
`timescale 1ns/10ps
`default_nettype none
module char_lcd_instruction_interface_tb;
    import clii_pkg::*;
    typedef struct packed {
        logic [1:0] mode;
        logic sel;
        logic [7:0] code;
        logic [5:0] flags;
        logic [6:0] addr;
        logic [6:0] shift;
    } clii_row_t;
    localparam clii_row_t ROWS [19] = '{
        '{2'h0, 1'b0, 8'h3b, 6'h0a, 7'h00, 7'h00},
        '{2'h0, 1'b0, 8'h0e, 6'h3a, 7'h00, 7'h00},
        '{2'h0, 1'b0, 8'h06, 6'h3a, 7'h00, 7'h00},
        '{2'h0, 1'b1, 8'h4c, 6'h3a, 7'h01, 7'h00},
        '{2'h0, 1'b1, 8'h43, 6'h3a, 7'h02, 7'h00},
        '{2'h0, 1'b0, 8'hc0, 6'h3a, 7'h40, 7'h00},
        '{2'h0, 1'b1, 8'h4e, 6'h3a, 7'h41, 7'h00},
        '{2'h0, 1'b0, 8'h07, 6'h3a, 7'h41, 7'h00},
        '{2'h0, 1'b1, 8'h4f, 6'h3a, 7'h42, 7'h01},
        '{2'h0, 1'b0, 8'h02, 6'h3a, 7'h00, 7'h00},
        '{2'h0, 1'b0, 8'ha7, 6'h3a, 7'h27, 7'h00},
        '{2'h0, 1'b1, 8'h41, 6'h3a, 7'h40, 7'h01},
        '{2'h3, 1'b0, 8'h20, 6'h30, 7'h40, 7'h01},
        '{2'h2, 1'b0, 8'h28, 6'h38, 7'h40, 7'h01},
        '{2'h2, 1'b1, 8'h5a, 6'h38, 7'h41, 7'h02},
        '{2'h2, 1'b0, 8'h1c, 6'h38, 7'h42, 7'h03},
        '{2'h2, 1'b0, 8'h10, 6'h38, 7'h41, 7'h03},
        '{2'h2, 1'b0, 8'h40, 6'h39, 7'h41, 7'h03},
        '{2'h2, 1'b1, 8'h1f, 6'h39, 7'h41, 7'h03}
    };
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = '0;
    logic [31:0] wdata = '0;
    logic [31:0] araddr = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [6:0] rd_index = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    logic display_on, cursor_on, blink_on, two_line, font_large, bus_8bit, glyph_selected;
    logic [6:0] cursor_addr, display_shift;
    logic [7:0] rd_char, glyph_rd;
    logic [19:0] flg;
    int bad_count = 0;
    int check_count = 0;
    assign flg = {display_on, cursor_on, two_line, font_large, bus_8bit, glyph_selected,
                  cursor_addr, display_shift};

    clii_bus_if bus ();
    always #2 aclk = ~aclk;

    clii_host u_clii_host (.bus(bus), .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    clii_device u_clii_device (.bus(bus), .aclk(aclk), .aresetn(aresetn),
        .rd_index(rd_index), .rd_char(rd_char), .glyph_rd_index(6'h00), .glyph_rd_data(glyph_rd),
        .display_on(display_on), .cursor_on(cursor_on), .blink_on(blink_on),
        .two_line(two_line), .font_large(font_large), .bus_8bit(bus_8bit),
        .glyph_selected(glyph_selected), .cursor_addr(cursor_addr),
        .display_shift(display_shift));
    clii_bus_props u_clii_bus_props (.aclk(aclk), .aresetn(aresetn), .strobe(bus.strobe),
        .instr_data_select(bus.instr_data_select), .read_not_write(bus.read_not_write),
        .high_nibble_lines(bus.high_nibble_lines), .low_nibble_lines(bus.low_nibble_lines));

    task automatic results();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Waits for one handshake at the falling edge, then lets the taking edge pass.
    task automatic hs(input int k);
        int n;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while ((k == 0 ? awready & wready : k == 1 ? bvalid : k == 2 ? arready : rvalid)
                   !== 1'b1 && n < 300);
        if (n >= 300) begin
            chk(32'h0, 32'h1);
            results();
        end
        resp = k == 1 ? bresp : rresp;
        rd = rdata;
        @(posedge aclk);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        hs(0);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        hs(1);
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [31:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        hs(2);
        arvalid <= 1'b0;
        hs(3);
        rready <= 1'b0;
    endtask

    task automatic idle();
        int n;
        n = 0;
        rd = 32'h1;
        while (rd[STATUS_BUSY_BIT] !== 1'b0 && n < 300) begin
            rdr({28'h0, REG_STATUS});
            n++;
        end
        if (n >= 300) begin
            chk(32'h0, 32'h1);
            results();
        end
        repeat (6) @(posedge aclk);
    endtask

    task automatic send(input clii_row_t r);
        wr({28'h0, REG_MODE}, {31'h0, r.mode[1]});
        wr({28'h0, REG_CMD}, {22'h0, r.mode[0], r.sel, r.code});
        chk({30'h0, resp}, {30'h0, RESP_OKAY});
        idle();
        chk({12'h0, flg}, {12'h0, r.flags, r.addr, r.shift});
    endtask

    task automatic mem(input logic [6:0] idx, input logic [7:0] exp);
        @(posedge aclk);
        rd_index <= idx;
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk({24'h0, rd_char}, {24'h0, exp});
    endtask

    task automatic rst();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk({12'h0, flg}, {12'h0, 6'h02, 14'h0});
        chk({29'h0, bus.strobe, bvalid, rvalid}, 32'h0);
    endtask

    initial begin
        rst();
        for (int i = 0; i < 19; i++) begin
            send(ROWS[i]);
        end
        mem(7'h00, 8'h4c);
        mem(7'h01, 8'h43);
        mem(7'h27, 8'h41);
        mem(7'h28, 8'h5a);
        mem(7'h29, 8'h4f);
        mem(7'h50, BLANK_CODE);
        chk({24'h0, glyph_rd}, 32'h0000_001f);
        // A clear blanks the character memory and reselects it.
        send('{2'h2, 1'b0, 8'h01, 6'h38, 7'h00, 7'h00});
        mem(7'h28, BLANK_CODE);
        // A second order while the link is busy is refused.
        wr({28'h0, REG_CMD}, 32'h0000_0008);
        chk({30'h0, resp}, {30'h0, RESP_OKAY});
        wr({28'h0, REG_CMD}, 32'h0000_000f);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        idle();
        chk({30'h0, display_on, blink_on}, 32'h0);
        wr(32'h0000_001c, 32'h0);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        rdr(32'h0000_000c);
        chk(rd, 32'h0);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        rst();
        results();
    end
endmodule
`default_nettype wire
